// ==== iox_pkg.sv ====
// Package for the indexed offset execute block: encodings, register map,
// field layouts and reset values.
// Assumes a 12-bit data memory space and an 8-bit data path.
// Functional notes
// - Indexed add: W plus byte at pointer+offset
// - Indexed add updates all five status flags
// - Destination bit: clear to W, set to memory
// - Indexed bit-set sets chosen bit, flags unchanged
// - Indexed set-all writes all ones, flags unchanged
// - One word, one cycle, four quadrature phases
// - Enabled: operand at/below boundary is pointer offset
// - Extended-set enable bit defaults to zero
// - Disabled: access bit picks access bank or bank
// - Offset only when enabled and access bit clear
package iox_pkg;
  localparam int          ADDR_W      = 12;
  localparam logic [7:0]  OFS_LIMIT   = 8'h5f;
  localparam logic [7:0]  ALL_ONES    = 8'hff;
  localparam logic [3:0]  ACC_HI_BANK = 4'hf;
  // Opcode patterns on bits 15:8 (with masks)
  localparam logic [7:0]  OP_ADD_MASK = 8'hfc;
  localparam logic [7:0]  OP_ADD      = 8'h24;
  localparam logic [7:0]  OP_BIT_MASK = 8'hf0;
  localparam logic [7:0]  OP_BIT      = 8'h80;
  localparam logic [7:0]  OP_SET_MASK = 8'hfe;
  localparam logic [7:0]  OP_SET      = 8'h68;
  // Field positions within the instruction word
  localparam int          DEST_BIT    = 9;
  localparam int          ACC_BIT     = 8;
  localparam int          BITSEL_LSB  = 9;
  // Status flag positions
  localparam int          FLG_C       = 0;
  localparam int          FLG_DCY     = 1;
  localparam int          FLG_Z       = 2;
  localparam int          FLG_OVF     = 3;
  localparam int          FLG_N       = 4;
  // Register map (word addresses on the Avalon slave)
  localparam logic [2:0]  REG_CTRL    = 3'h0;
  localparam logic [2:0]  REG_WREG    = 3'h1;
  localparam logic [2:0]  REG_STATUS  = 3'h2;
  localparam logic [2:0]  REG_FRAME   = 3'h3;
  localparam logic [2:0]  REG_BANK    = 3'h4;
  localparam logic [2:0]  REG_INSTR   = 3'h5;
  localparam logic [2:0]  REG_EADDR   = 3'h6;
  // Reset values
  localparam logic        EXT_RST     = 1'b0;
  localparam logic [7:0]  WREG_RST    = 8'h00;
  localparam logic [4:0]  STAT_RST    = 5'h00;
  localparam logic [11:0] FRAME_RST   = 12'h000;
  localparam logic [3:0]  BANK_RST    = 4'h0;

  // Quadrature phase of one instruction cycle
  typedef enum logic [1:0] {
    IOX_Q1 = 2'b00,
    IOX_Q2 = 2'b01,
    IOX_Q3 = 2'b10,
    IOX_Q4 = 2'b11
  } iox_phase_t;

  // Decoded operation
  typedef enum logic [1:0] {
    IOX_NOP = 2'b00,
    IOX_ADD = 2'b01,
    IOX_BIT = 2'b10,
    IOX_SET = 2'b11
  } iox_op_t;

  // Avalon-MM request bundle
  typedef struct packed {
    logic        read;
    logic        write;
    logic [2:0]  address;
    logic [31:0] writedata;
  } iox_avreq_t;

  // Data memory port bundle
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } iox_mem_t;
endpackage

// ==== iox_dmem.sv ====
// Small data memory for the indexed execute block.
// Assumes one clock; read data come out of a register.
`timescale 1ns/10ps
module iox_dmem #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // Clock and enable
  input  wire logic          i_mclk,
  input  wire logic          i_ce,
  // Access port
  input  wire logic          i_wr,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  output logic      [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Read first (old contents on a write), registered read
  always_ff @(posedge i_mclk) begin
    if (i_ce) begin
      if (i_wr) begin
        mem[i_addr] <= i_wdata;
      end
      o_rdata <= mem[i_addr];
    end
  end
endmodule

// ==== iox_core.sv ====
// Top of the indexed offset execute block: register slave, decode,
// address formation and four-phase execution against a data memory.
// Assumes an Avalon-MM master; a write to the instruction register starts
// one instruction cycle.
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
module iox_core #(
  parameter int ADDR_W = iox_pkg::ADDR_W
) (
  // Clock, reset, enable
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic        i_ce,
  // Avalon-MM slave
  input  wire logic [2:0]  i_av_address,
  input  wire logic        i_av_read,
  input  wire logic        i_av_write,
  input  wire logic [31:0] i_av_writedata,
  output logic      [31:0] o_av_readdata,
  output logic             o_av_waitrequest,
  // Execution status
  output logic             o_busy
);
  // Only the 12-bit data space is served
  if (ADDR_W != 12) begin : g_bad_addr_w
    $error("iox_core supports only a 12-bit space");
  end

  iox_pkg::iox_avreq_t req;
  assign req = '{read: i_av_read, write: i_av_write,
                 address: i_av_address, writedata: i_av_writedata};

  // State registers
  logic                ext_reg,   ext_next;
  logic [7:0]          w_reg,     w_next;
  logic [4:0]          stat_reg,  stat_next;
  logic [11:0]         frame_reg, frame_next;
  logic [3:0]          bank_reg,  bank_next;
  logic [15:0]         ins_reg,   ins_next;
  logic [11:0]         ea_reg,    ea_next;
  logic [7:0]          res_reg,   res_next;
  iox_pkg::iox_phase_t ph_reg,    ph_next;
  logic                run_reg,   run_next;
  logic [31:0]         rd_reg,    rd_next;
  logic                ack_reg,   ack_next;
  iox_pkg::iox_mem_t   mem;
  logic [7:0]          mem_rdata;

  // Decode the opcode byte into an operation
  function automatic iox_pkg::iox_op_t dec_op(input logic [15:0] ins);
    if ((ins[15:8] & iox_pkg::OP_ADD_MASK) == iox_pkg::OP_ADD)
      return iox_pkg::IOX_ADD;
    else if ((ins[15:8] & iox_pkg::OP_BIT_MASK) == iox_pkg::OP_BIT)
      return iox_pkg::IOX_BIT;
    else if ((ins[15:8] & iox_pkg::OP_SET_MASK) == iox_pkg::OP_SET)
      return iox_pkg::IOX_SET;
    else
      return iox_pkg::IOX_NOP;
  endfunction

  // Effective address from operand, access bit and mode
  function automatic logic [11:0] eff_addr(input logic [15:0] ins,
                                            input logic ext,
                                            input logic [11:0] fp,
                                            input logic [3:0] bank);
    logic [7:0] f;
    f = ins[7:0];
    if (ext && !ins[iox_pkg::ACC_BIT] && f <= iox_pkg::OFS_LIMIT)
      return 12'(fp + {4'h0, f});
    else if (ins[iox_pkg::ACC_BIT])
      return {bank, f};
    else if (f <= iox_pkg::OFS_LIMIT)
      return {4'h0, f};
    else
      return {iox_pkg::ACC_HI_BANK, f};
  endfunction

  iox_pkg::iox_op_t op;
  assign op = dec_op(ins_reg);

  // Adder with full flag set
  logic [8:0] sum9;
  logic [4:0] sum_lo;
  assign sum9   = {1'b0, w_reg} + {1'b0, mem_rdata};
  assign sum_lo = {1'b0, w_reg[3:0]} + {1'b0, mem_rdata[3:0]};

  // Next-state logic: bus slave and four-phase execution
  always_comb begin
    ext_next   = ext_reg;
    w_next     = w_reg;
    stat_next  = stat_reg;
    frame_next = frame_reg;
    bank_next  = bank_reg;
    ins_next   = ins_reg;
    ea_next    = ea_reg;
    res_next   = res_reg;
    ph_next    = ph_reg;
    run_next   = run_reg;
    rd_next    = rd_reg;
    ack_next   = 1'b0;
    mem        = '{rd: 1'b0, wr: 1'b0, addr: ea_reg, wdata: res_reg};
    if (run_reg) begin
      case (ph_reg)
        iox_pkg::IOX_Q1: begin
          ea_next = eff_addr(ins_reg, ext_reg, frame_reg, bank_reg);
          ph_next = iox_pkg::IOX_Q2;
        end
        iox_pkg::IOX_Q2: begin
          mem.rd  = 1'b1;
          ph_next = iox_pkg::IOX_Q3;
        end
        iox_pkg::IOX_Q3: begin
          case (op)
            iox_pkg::IOX_ADD: begin
              res_next = sum9[7:0];
              stat_next[iox_pkg::FLG_C]  = sum9[8];
              stat_next[iox_pkg::FLG_DCY] = sum_lo[4];
              stat_next[iox_pkg::FLG_Z]  = (sum9[7:0] == 8'h00);
              stat_next[iox_pkg::FLG_N]  = sum9[7];
              stat_next[iox_pkg::FLG_OVF] = (w_reg[7] == mem_rdata[7]) &&
                                           (sum9[7] != w_reg[7]);
            end
            iox_pkg::IOX_BIT: begin
              res_next = mem_rdata |
                (8'h01 << ins_reg[iox_pkg::BITSEL_LSB +: 3]);
            end
            iox_pkg::IOX_SET: res_next = iox_pkg::ALL_ONES;
            default:          res_next = mem_rdata;
          endcase
          ph_next = iox_pkg::IOX_Q4;
        end
        iox_pkg::IOX_Q4: begin
          if (op == iox_pkg::IOX_ADD && !ins_reg[iox_pkg::DEST_BIT]) begin
            w_next = res_reg;
          end else if (op != iox_pkg::IOX_NOP) begin
            mem.wr = 1'b1;
          end
          ph_next  = iox_pkg::IOX_Q1;
          run_next = 1'b0;
        end
        default: ph_next = iox_pkg::IOX_Q1;
      endcase
    end
    // Register accesses; instruction writes wait while one runs
    if ((req.read || req.write) && !ack_reg &&
        !(run_reg && req.write && req.address == iox_pkg::REG_INSTR)) begin
      ack_next = 1'b1;
      rd_next  = 32'h0;
      if (req.write) begin
        case (req.address)
          iox_pkg::REG_CTRL:  ext_next = req.writedata[0];
          iox_pkg::REG_WREG:  w_next = req.writedata[7:0];
          iox_pkg::REG_STATUS: begin
            // A flag update from the add wins over a software write
            if (!(run_reg && ph_reg == iox_pkg::IOX_Q3 &&
                  op == iox_pkg::IOX_ADD)) begin
              stat_next = req.writedata[4:0];
            end
          end
          iox_pkg::REG_FRAME: frame_next = req.writedata[11:0];
          iox_pkg::REG_BANK:  bank_next = req.writedata[3:0];
          iox_pkg::REG_INSTR: begin
            ins_next = req.writedata[15:0];
            run_next = 1'b1;
            ph_next  = iox_pkg::IOX_Q1;
          end
          default: ;
        endcase
      end else begin
        case (req.address)
          iox_pkg::REG_CTRL:   rd_next = {31'h0, ext_reg};
          iox_pkg::REG_WREG:   rd_next = {24'h0, w_reg};
          iox_pkg::REG_STATUS: rd_next = {26'h0, run_reg, stat_reg};
          iox_pkg::REG_FRAME:  rd_next = {20'h0, frame_reg};
          iox_pkg::REG_BANK:   rd_next = {28'h0, bank_reg};
          iox_pkg::REG_INSTR:  rd_next = {16'h0, ins_reg};
          iox_pkg::REG_EADDR:  rd_next = {20'h0, ea_reg};
          default:             rd_next = 32'h0;
        endcase
      end
    end
  end


  // Register all state
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      ext_reg   <= iox_pkg::EXT_RST;
      w_reg     <= iox_pkg::WREG_RST;
      stat_reg  <= iox_pkg::STAT_RST;
      frame_reg <= iox_pkg::FRAME_RST;
      bank_reg  <= iox_pkg::BANK_RST;
      ins_reg   <= 16'h0000;
      ea_reg    <= 12'h000;
      res_reg   <= 8'h00;
      ph_reg    <= iox_pkg::IOX_Q1;
      run_reg   <= 1'b0;
      rd_reg    <= 32'h0;
      ack_reg   <= 1'b0;
    end else if (i_ce) begin
      ext_reg   <= ext_next;
      w_reg     <= w_next;
      stat_reg  <= stat_next;
      frame_reg <= frame_next;
      bank_reg  <= bank_next;
      ins_reg   <= ins_next;
      ea_reg    <= ea_next;
      res_reg   <= res_next;
      ph_reg    <= ph_next;
      run_reg   <= run_next;
      rd_reg    <= rd_next;
      ack_reg   <= ack_next;
    end
  end

  assign o_av_readdata    = rd_reg;
  assign o_av_waitrequest = (i_av_read || i_av_write) && !ack_reg;
  assign o_busy           = run_reg;

  iox_dmem #(
    .AW (ADDR_W),
    .DW (8)
  ) iox_dmem_inst (
    .i_mclk  (i_mclk),
    .i_ce    (i_ce),
    .i_wr    (mem.wr),
    .i_addr  (mem.addr),
    .i_wdata (mem.wdata),
    .o_rdata (mem_rdata)
  );

  // Checks
  cycle_len_a: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    i_ce && run_reg && ph_reg == iox_pkg::IOX_Q1 ##1 i_ce [*3]
    |=> !run_reg)
    else $error("instruction not done in four phases");
  ext_reset_a: assert property (
    @(posedge i_mclk) $rose(i_resetn) |-> !ext_reg)
    else $error("extended enable not clear after reset");
  set_flags_a: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    run_reg && op != iox_pkg::IOX_ADD && ph_reg == iox_pkg::IOX_Q3 && i_ce
    |=> $stable(stat_reg))
    else $error("flags changed by non-add");
  set_all_a: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    mem.wr && op == iox_pkg::IOX_SET |-> mem.wdata == iox_pkg::ALL_ONES)
    else $error("set-all wrote other than ones");
  add_dest_a: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    mem.wr && op == iox_pkg::IOX_ADD |-> ins_reg[iox_pkg::DEST_BIT])
    else $error("add wrote memory with destination clear");
  add_sum_a: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    run_reg && ph_reg == iox_pkg::IOX_Q3 && op == iox_pkg::IOX_ADD && i_ce
    |=> res_reg == 8'($past(w_reg) + $past(mem_rdata)))
    else $error("add result wrong");
  zero_flag_a: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    run_reg && ph_reg == iox_pkg::IOX_Q3 && op == iox_pkg::IOX_ADD && i_ce
    |=> stat_reg[iox_pkg::FLG_Z] == (res_reg == 8'h00))
    else $error("zero flag wrong");
  ofs_addr_a: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    run_reg && ph_reg == iox_pkg::IOX_Q1 && i_ce && ext_reg &&
    !ins_reg[iox_pkg::ACC_BIT] && ins_reg[7:0] <= iox_pkg::OFS_LIMIT
    |=> ea_reg == 12'($past(frame_reg) + $past(ins_reg[7:0])))
    else $error("indexed address wrong");
  bank_addr_a: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    run_reg && ph_reg == iox_pkg::IOX_Q1 && i_ce && ins_reg[iox_pkg::ACC_BIT]
    |=> ea_reg == {$past(bank_reg), $past(ins_reg[7:0])})
    else $error("banked address wrong");
  lit_addr_a: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    run_reg && ph_reg == iox_pkg::IOX_Q1 && i_ce &&
    !ins_reg[iox_pkg::ACC_BIT] && ins_reg[7:0] > iox_pkg::OFS_LIMIT
    |=> ea_reg == {iox_pkg::ACC_HI_BANK, $past(ins_reg[7:0])})
    else $error("high access operand remapped");
endmodule

// ==== iox_alu_model.sv ====
// Behavioural data memory and ALU standing past the indexed execute block.
// Assumes the bench calls run once per finished instruction, in order.
`timescale 1ns/10ps
module iox_alu_model;
  logic [7:0]  mem [4096];
  logic [7:0]  w = iox_pkg::WREG_RST;
  logic [4:0]  flg = iox_pkg::STAT_RST;
  logic [11:0] ea;

  // Effective address first, then the operation on the addressed byte
  task automatic run(input logic [15:0] ins, input logic ext,
                     input logic [11:0] fp, input logic [3:0] bank);
    logic [8:0] s;
    logic [7:0] m;
    if (ins[8])
      ea = {bank, ins[7:0]};
    else if (ext && ins[7:0] <= 8'h5f)
      ea = fp + 12'(ins[7:0]);
    else
      ea = {(ins[7:0] > 8'h5f) ? 4'hf : 4'h0, ins[7:0]};
    m = mem[ea];
    if (ins[15:10] == 6'b001001) begin
      s = {1'b0, w} + {1'b0, m};
      flg = {s[7], (w[7] == m[7]) && (s[7] != w[7]), s[7:0] == 8'h00,
             ({1'b0, w[3:0]} + {1'b0, m[3:0]}) > 5'h0f, s[8]};
      if (ins[9])
        mem[ea] = s[7:0];
      else
        w = s[7:0];
    end else if (ins[15:12] == 4'h8) begin
      mem[ea] = m | (8'h01 << ins[11:9]);
    end else if (ins[15:9] == 7'b0110100) begin
      mem[ea] = 8'hff;
    end
  endtask
endmodule

// ==== iox_core_test.sv ====
// Self-checking bench for the indexed offset execute block.
// Assumes register access over Avalon-MM and the behavioural memory model.
`timescale 1ns/10ps
module iox_core_test;
  typedef struct {string nm; logic [31:0] v;} iox_exp_t;
  logic        i_mclk = 1'b0;
  logic        i_resetn = 1'b0;
  logic [2:0]  av_addr = 3'h0;
  logic        av_rd = 1'b0;
  logic        av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h0;
  logic [31:0] rdata;
  logic        waitreq;
  logic        busy;
  iox_exp_t    expq [$];
  iox_exp_t    got;
  int          fails = 0;
  int          n_checks = 0;
  logic [31:0] seed = 32'hce44a3b3;
  logic [31:0] r;
  logic [8:0]  af;
  logic        ext = 1'b0;
  logic [11:0] fp = 12'h000;
  logic [3:0]  bank = 4'h0;
  logic        ce = 1'b1;
  int          stall = 0;

  // Clock at 200 MHz
  always #2.5 i_mclk = ~i_mclk;

  iox_core iox_core_inst (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(ce),
    .i_av_address(av_addr), .i_av_read(av_rd), .i_av_write(av_wr),
    .i_av_writedata(av_wdata), .o_av_readdata(rdata),
    .o_av_waitrequest(waitreq), .o_busy(busy)
  );
  iox_alu_model iox_alu_model_inst ();

  // Pseudo-random source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Compares one value and counts it
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Takes the oldest note whenever read data are handed over
  always @(posedge i_mclk) begin
    if (av_rd && !waitreq) begin
      if (expq.size() == 0) begin
        fails++;
        $display("CHECK FAILED readdata expected none seen %h", rdata);
      end else begin
        got = expq.pop_front();
        check(got.nm, rdata, got.v);
      end
    end
  end

  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(logic rd, logic [2:0] a, logic [31:0] d);
    @(posedge i_mclk);
    av_addr <= a;
    av_wdata <= d;
    av_rd <= rd;
    av_wr <= !rd;
    do @(posedge i_mclk); while (waitreq);
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask

  task automatic rd(logic [2:0] a, logic [31:0] v, string nm);
    expq.push_back('{nm, v});
    bus(1'b1, a, 32'h0);
  endtask

  task automatic wrw(logic [7:0] v);
    bus(1'b0, iox_pkg::REG_WREG, {24'h0, v});
    iox_alu_model_inst.w = v;
  endtask

  task automatic cfg(logic e, logic [11:0] f, logic [3:0] b);
    ext = e;
    fp = f;
    bank = b;
    bus(1'b0, iox_pkg::REG_CTRL, {31'h0, e});
    bus(1'b0, iox_pkg::REG_FRAME, {20'h0, f});
    bus(1'b0, iox_pkg::REG_BANK, {28'h0, b});
  endtask

  // Runs one instruction, then reads address, W and flags; a nonzero stall
  // drops the clock enable for that many cycles inside the instruction
  task automatic exec(logic [15:0] ins);
    int n = 0;
    bus(1'b0, iox_pkg::REG_INSTR, {16'h0, ins});
    for (int i = 0; i < 20 && busy; i++) begin
      n++;
      ce <= !(i >= 1 && i <= stall);
      @(posedge i_mclk);
    end
    ce <= 1'b1;
    check("busy cycles", 32'(n), 32'(4 + stall));
    iox_alu_model_inst.run(ins, ext, fp, bank);
    rd(iox_pkg::REG_EADDR, {20'h0, iox_alu_model_inst.ea},
       "eaddr");
    rd(iox_pkg::REG_WREG, {24'h0, iox_alu_model_inst.w},
       "wreg");
    rd(iox_pkg::REG_STATUS, {27'h0, iox_alu_model_inst.flg},
       "flags");
  endtask

  // Puts a known byte at an operand: set-all, then add W back to memory
  task automatic load(logic [8:0] a, logic [7:0] v);
    wrw(v + 8'h01);
    exec({7'b0110100, a});
    exec({7'b0010011, a});
  endtask

  // Reads a byte back into W through an add to a cleared W
  task automatic peek(logic [8:0] a);
    wrw(8'h00);
    exec({7'b0010010, a});
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge i_mclk);
    fails++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge i_mclk);
    i_resetn <= 1'b1;
    // Reset values and one unmapped word
    for (int a = 0; a < 8; a++)
      if (a < 5 || a == 7)
        rd(3'(a), 32'h0, "reset value");
    // Extension off: literal access bank and bank select
    cfg(1'b0, 12'ha00, 4'h3);
    load(9'h010, 8'h5a);
    load(9'h121, 8'h33);
    load(9'h070, 8'h66);
    // Extension on: add, bit-set every bit, boundary and access bit
    cfg(1'b1, 12'ha00, 4'h3);
    load(9'h02c, 8'h20);
    wrw(8'h17);
    exec({7'b0010010, 9'h02c});
    load(9'h030, 8'h80);
    wrw(8'h80);
    exec({7'b0010010, 9'h030});
    load(9'h00a, 8'h55);
    for (int b = 0; b < 8; b++) begin
      exec({4'h8, 3'(b), 9'h00a});
      peek(9'h00a);
    end
    load(9'h05f, 8'h11);
    load(9'h060, 8'h22);
    load(9'h110, 8'h77);
    // Pointer plus offset past the top of memory
    cfg(1'b1, 12'hff0, 4'h3);
    load(9'h020, 8'h44);
    // Random pointers, offsets, operands and destinations
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      cfg(1'b1, r[11:0], r[15:12]);
      af = {1'b0, r[23:16] % 8'h60};
      load(af, r[31:24]);
      r = rnd();
      wrw(r[7:0]);
      stall = int'(r[10:9]);
      exec({6'b001001, r[8], af});
      peek(af);
    end
    tally_and_finish();
  end
endmodule
